// [hw/cdgm_gain_mute.sv]
`timescale 1ns/1ps
// Summary of operation
// - limiter release time holds a seven-bit count of time units.
// - release unit bit picks ten millisecond units when set, one millisecond otherwise.
// - mute style after reset: zero soft, one hard; defaults to hard.
// - gain changes wait for a zero crossing unless immediate change is selected.
// - auto silence mutes on a long run of zero samples; enabled by default.
// - zero-run code picks 512, 1k, 2k or 4k samples; default code two.
// - bypass bit removes the gain multiply from the audio path.
// - ramp enable moves gain toward the new setting in single steps.
// - ramp interval is one shifted left by the exponent, default five.
// - ramp unit bit picks ten millisecond units when set, one otherwise.
// - writing one to the clear bit clears both limit latches.
// - left and right silence bits mute their channel independently.
// - a global mute input silences all channels.
// - level cut is half a dB per count; FFh hard mutes everything.
// - level cut applies equally to both channels; resets to 0 dB.
// - on release steps below threshold, limiter cut falls by the increment, floor zero.
// - limiter increment code selects 0.5, 1, 2 or 4 dB.
module cdgm_gain_mute
  import cdgm_pkg::*;
#(
  parameter int unsigned SAMPLES_PER_UNIT = SAMPLES_PER_MS
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        global_silence,
  input  wire logic [1:0]  limiter_step_code,
  input  wire logic        limiter_attack_step,
  input  wire logic        limiter_release_over,
  input  wire logic [1:0]  limit_hit,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire cdgm_frame_s in_frame,
  output logic             out_valid,
  input  wire logic        out_ready,
  output cdgm_frame_s      out_frame,
  output logic      [1:0]  limit_flag_status,
  output logic      [7:0]  limiter_cut,
  output logic             auto_silenced
);

  if (SAMPLES_PER_UNIT < 1 || SAMPLES_PER_UNIT > 65535) begin : g_bad_rate
    $error("cdgm_gain_mute: SAMPLES_PER_UNIT out of range");
  end

  // address match, shared by the read and write decoders
  function automatic logic reg_sel(input logic [15:0] addr, input logic [15:0] target);
    reg_sel = (addr == target);
  endfunction : reg_sel

  // scale by 10^(-att/40); attenuation splits into 6 dB shifts and a half-dB mantissa
  function automatic cdgm_sample_t scale_sample(input cdgm_sample_t s, input logic [8:0] att);
    logic [8:0]         octave;
    logic [8:0]         frac;
    logic [15:0]        mant;
    logic signed [40:0] prod;
    octave = att / ATT_OCTAVE;
    frac   = att % ATT_OCTAVE;
    case (frac)
      9'h000:  mant = 16'h8000;
      9'h001:  mant = 16'h78D6;
      9'h002:  mant = 16'h7215;
      9'h003:  mant = 16'h6BB3;
      9'h004:  mant = 16'h65AD;
      9'h005:  mant = 16'h5FFD;
      9'h006:  mant = 16'h5A9E;
      9'h007:  mant = 16'h558C;
      9'h008:  mant = 16'h50C3;
      9'h009:  mant = 16'h4C3F;
      9'h00A:  mant = 16'h47FB;
      default: mant = 16'h43F4;
    endcase
    prod = $signed({{17{s[SAMPLE_W-1]}}, s}) * $signed({25'h0000000, mant});
    scale_sample = SAMPLE_W'(prod >>> (MANT_FRAC_BITS + 32'(octave)));
  endfunction : scale_sample

  // registers
  logic [7:0] release_time;
  logic [7:0] gain_high;
  logic [7:0] gain_low;
  logic [7:0] silence;
  logic [7:0] level_cut;
  cdgm_boot_e boot_state;

  // write and read decode
  wire wr_release = reg_write && reg_sel(reg_addr, ADDR_RELEASE_TIME);
  wire wr_high    = reg_write && reg_sel(reg_addr, ADDR_GAIN_HIGH);
  wire wr_low     = reg_write && reg_sel(reg_addr, ADDR_GAIN_LOW);
  wire wr_silence = reg_write && reg_sel(reg_addr, ADDR_SILENCE);
  wire wr_cut     = reg_write && reg_sel(reg_addr, ADDR_LEVEL_CUT);
  wire clear_latch = wr_low && reg_wdata[GL_CLR_BIT];
  wire [7:0] rd_word =
    reg_sel(reg_addr, ADDR_RELEASE_TIME) ? release_time :
    reg_sel(reg_addr, ADDR_GAIN_HIGH)    ? gain_high :
    reg_sel(reg_addr, ADDR_GAIN_LOW)     ? gain_low :
    reg_sel(reg_addr, ADDR_SILENCE)      ? silence :
    reg_sel(reg_addr, ADDR_LEVEL_CUT)    ? level_cut : 8'h00;

  // control field views
  wire       hard_style   = gain_low[GL_HARD_BIT];
  wire       immediate    = gain_low[GL_IMMEDIATE_BIT];
  wire       auto_enable  = gain_low[GL_AUTO_BIT];
  wire       bypass       = gain_low[GL_BYPASS_BIT];
  wire       ramp_enable  = gain_low[GL_RAMP_EN_BIT];
  wire       ramp_long    = gain_low[GL_RAMP_UNIT_BIT];
  wire [2:0] ramp_exp     = gain_high[GH_EXP_LSB +: 3];
  wire [1:0] zero_len     = gain_high[GH_ZLEN_LSB +: 2];
  wire       release_long = release_time[REL_UNIT_BIT];
  wire [6:0] release_cnt  = release_time[REL_TIME_MSB:0];

  // register file; reads return one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      release_time <= RST_RELEASE_TIME;
      gain_high    <= RST_GAIN_HIGH;
      gain_low     <= RST_GAIN_LOW;
      silence      <= RST_SILENCE;
      level_cut    <= RST_LEVEL_CUT;
      reg_rdata    <= 8'h00;
    end else begin
      if (wr_release) release_time <= reg_wdata;
      if (wr_high)    gain_high    <= reg_wdata;
      if (wr_low)     gain_low     <= reg_wdata;
      if (wr_silence) silence      <= reg_wdata;
      if (wr_cut)     level_cut    <= reg_wdata;
      if (reg_read)   reg_rdata    <= rd_word;
    end
  end

  // outputs stay muted after reset until software touches the silence or level registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boot_state <= CDGM_HOLD_SILENT;
    end else begin
      case (boot_state)
        CDGM_HOLD_SILENT: if (wr_silence || wr_cut) boot_state <= CDGM_RUN;
        CDGM_RUN:         boot_state <= CDGM_RUN;
        default:          boot_state <= CDGM_HOLD_SILENT;
      endcase
    end
  end

  // limit latches: a hit in the clearing cycle survives
  always_ff @(posedge clock or posedge reset) begin
    if (reset) limit_flag_status <= 2'h0;
    else       limit_flag_status <= (limit_flag_status & {2{!clear_latch}}) | limit_hit;
  end

  // sample-counted time bases; time only advances while audio flows
  logic [15:0] ms_count;
  logic [3:0]  ten_count;
  logic [7:0]  ramp_count;
  logic [6:0]  rel_count;
  wire         take       = in_valid && in_ready;
  wire         ms_tick    = take && (ms_count == 16'(SAMPLES_PER_UNIT - 1));
  wire         ten_tick   = ms_tick && (ten_count == LONG_UNIT_MS - 4'h1);
  wire         ramp_unit  = ramp_long ? ten_tick : ms_tick;
  wire         rel_unit   = release_long ? ten_tick : ms_tick;
  wire [7:0]   ramp_last  = 8'((9'h001 << ramp_exp) - 9'h001);
  wire         ramp_go    = ramp_unit && (ramp_count >= ramp_last);
  wire [6:0]   rel_last   = (release_cnt == 7'h00) ? 7'h00 : release_cnt - 7'h01;
  wire         release_go = rel_unit && (rel_count >= rel_last);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ms_count   <= 16'h0000;
      ten_count  <= 4'h0;
      ramp_count <= 8'h00;
      rel_count  <= 7'h00;
    end else begin
      if (take)      ms_count   <= ms_tick ? 16'h0000 : ms_count + 16'h0001;
      if (ms_tick)   ten_count  <= ten_tick ? 4'h0 : ten_count + 4'h1;
      // a new exponent restarts the interval, so the count never runs past its end
      if (wr_high)        ramp_count <= 8'h00;
      else if (ramp_unit) ramp_count <= ramp_go ? 8'h00 : ramp_count + 8'h01;
      if (rel_unit)  rel_count  <= release_go ? 7'h00 : rel_count + 7'h01;
    end
  end

  // limiter cut in half-dB: attack raises it, release lowers it toward zero
  wire [8:0] lim_inc  = 9'(9'h001 << limiter_step_code);
  wire [8:0] lim_up   = {1'h0, limiter_cut} + lim_inc;
  wire       lim_fall = release_go && !limiter_release_over && !limiter_attack_step;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      limiter_cut <= 8'h00;
    end else if (limiter_attack_step) begin
      limiter_cut <= (lim_up > {1'h0, ATT_MAX_LIM}) ? ATT_MAX_LIM : lim_up[7:0];
    end else if (lim_fall) begin
      limiter_cut <= ({1'h0, limiter_cut} < lim_inc) ? 8'h00 : 8'(limiter_cut - lim_inc[7:0]);
    end
  end

  // zero-run detector across both channels
  logic [12:0] zero_run;
  wire  [12:0] zero_limit = 13'(ZERO_RUN_BASE << zero_len);
  wire         both_zero  = (in_frame.left == '0) && (in_frame.right == '0);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      zero_run      <= 13'h0000;
      auto_silenced <= 1'h0;
    end else begin
      if (take) zero_run <= !both_zero ? 13'h0000 : (zero_run == zero_limit) ? zero_run : zero_run + 13'h0001;
      auto_silenced <= auto_enable && (zero_run >= zero_limit);
    end
  end

  // per-channel gain path
  cdgm_sample_t chan_in   [2];
  cdgm_sample_t chan_out  [2];
  logic [8:0]   chan_att  [2];
  logic         chan_hard [2];
  assign chan_in[0] = in_frame.left;
  assign chan_in[1] = in_frame.right;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic       prev_sign;
    logic       step_due;
    logic [8:0] cur_att;
    wire        own_mute = ch == 0 ? silence[SIL_LEFT_BIT] : silence[SIL_RIGHT_BIT];
    wire        muted    = own_mute || global_silence || auto_silenced
                           || (boot_state == CDGM_HOLD_SILENT);
    wire        hard     = (level_cut == LEVEL_CUT_HARD) || (muted && hard_style);
    wire [8:0]  target   = muted ? ATT_SILENT : {1'h0, level_cut};
    wire        crossing = (chan_in[ch] == '0) || (chan_in[ch][SAMPLE_W-1] != prev_sign);
    wire        apply_ok = take && (immediate || crossing);
    wire [8:0]  stepped  = (cur_att < target) ? cur_att + 9'h001 :
                           (cur_att > target) ? cur_att - 9'h001 : cur_att;
    wire [9:0]  total    = {1'h0, cur_att} + {2'h0, limiter_cut};
    wire        silent   = hard || (total >= {1'h0, ATT_SILENT});

    assign chan_att[ch]  = cur_att;
    assign chan_hard[ch] = hard;
    // a hard mute zeroes at once; bypass skips the multiply but keeps silence
    assign chan_out[ch]  = silent ? '0 : bypass ? chan_in[ch] : scale_sample(chan_in[ch], total[8:0]);

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        prev_sign <= 1'h0;
        step_due  <= 1'h0;
        cur_att   <= ATT_SILENT;
      end else begin
        if (take) prev_sign <= chan_in[ch][SAMPLE_W-1];
        step_due <= ramp_go || (step_due && !apply_ok);
        if (apply_ok && !ramp_enable) cur_att <= target;
        else if (apply_ok && step_due) cur_att <= stepped;
      end
    end

    property p_ramp_single_step;
      @(posedge clock) disable iff (reset)
        ramp_enable && $past(ramp_enable) |->
          (cur_att == $past(cur_att)) || (cur_att == $past(cur_att) + 9'h001)
          || (cur_att == $past(cur_att) - 9'h001);
    endproperty
    a_ramp_single_step: assert property (p_ramp_single_step) else $error("ramp moved more than one step");

    property p_wait_crossing;
      @(posedge clock) disable iff (reset)
        !immediate && !(take && crossing) |=> $stable(cur_att);
    endproperty
    a_wait_crossing: assert property (p_wait_crossing) else $error("gain changed away from zero crossing");
  end

  cdgm_frame_s proc_frame;
  assign proc_frame.left  = chan_out[0];
  assign proc_frame.right = chan_out[1];

  // a stalled receiver fills the buffer and then holds in_ready low
  cdgm_pair_buf #(
    .WIDTH ($bits(cdgm_frame_s))
  ) u_pair_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (proc_frame),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_frame)
  );

  property p_latch_clear;
    @(posedge clock) disable iff (reset)
      clear_latch && (limit_hit == 2'h0) |=> limit_flag_status == 2'h0;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("limit latches not cleared");

  property p_latch_set_wins;
    @(posedge clock) disable iff (reset)
      limit_hit[0] |=> limit_flag_status[0] [*1] ##1 (limit_flag_status[0] || $past(clear_latch));
  endproperty
  a_latch_set_wins: assert property (p_latch_set_wins) else $error("limit hit lost");

  property p_master_hard;
    @(posedge clock) disable iff (reset)
      (level_cut == LEVEL_CUT_HARD) |-> (proc_frame == '0);
  endproperty
  a_master_hard: assert property (p_master_hard) else $error("hard master mute leaked audio");

  property p_left_hard;
    @(posedge clock) disable iff (reset)
      silence[SIL_LEFT_BIT] && hard_style |-> proc_frame.left == '0;
  endproperty
  a_left_hard: assert property (p_left_hard) else $error("left hard mute leaked audio");

  property p_bypass_pass;
    @(posedge clock) disable iff (reset)
      bypass && !chan_hard[1] && ({1'h0, chan_att[1]} + {2'h0, limiter_cut} < {1'h0, ATT_SILENT})
        |-> proc_frame.right == in_frame.right;
  endproperty
  a_bypass_pass: assert property (p_bypass_pass) else $error("bypass altered audio");

  property p_release_floor;
    @(posedge clock) disable iff (reset)
      lim_fall |=> limiter_cut == (({1'h0, $past(limiter_cut)} < $past(lim_inc)) ? 8'h00
                                   : 8'($past(limiter_cut) - $past(lim_inc[7:0])));
  endproperty
  a_release_floor: assert property (p_release_floor) else $error("release step wrong");

  property p_auto_cause;
    @(posedge clock) disable iff (reset)
      $rose(auto_silenced) |-> $past(auto_enable) && ($past(zero_run) >= $past(zero_limit));
  endproperty
  a_auto_cause: assert property (p_auto_cause) else $error("auto silence without zero run");

  property p_ramp_on_unit;
    @(posedge clock) disable iff (reset)
      ramp_go |-> (ramp_long ? ten_tick : ms_tick) && (ramp_count == ramp_last);
  endproperty
  a_ramp_on_unit: assert property (p_ramp_on_unit) else $error("ramp step off interval");

  c_auto_silence: cover property (@(posedge clock) disable iff (reset) $rose(auto_silenced));
  c_release_step: cover property (@(posedge clock) disable iff (reset) lim_fall && limiter_cut != 8'h00);
  c_buffer_stall: cover property (@(posedge clock) disable iff (reset) in_valid && !in_ready);
  c_soft_ramp:    cover property (@(posedge clock) disable iff (reset) ramp_enable && ramp_go);

endmodule : cdgm_gain_mute

// [hw/cdgm_pkg.sv]
package cdgm_pkg;

  // register byte addresses in the microcontroller space
  localparam logic [15:0] ADDR_RELEASE_TIME = 16'hA222;
  localparam logic [15:0] ADDR_GAIN_HIGH    = 16'hA223;
  localparam logic [15:0] ADDR_GAIN_LOW     = 16'hA224;
  localparam logic [15:0] ADDR_SILENCE      = 16'hA226;
  localparam logic [15:0] ADDR_LEVEL_CUT    = 16'hA227;

  // reset values
  localparam logic [7:0] RST_RELEASE_TIME = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH    = 8'h15;  // zero-run code 2, ramp exponent 5
  localparam logic [7:0] RST_GAIN_LOW     = 8'h05;  // hard mute style, auto silence on
  localparam logic [7:0] RST_SILENCE      = 8'h00;
  localparam logic [7:0] RST_LEVEL_CUT    = 8'h00;

  // field positions
  localparam int unsigned REL_UNIT_BIT     = 7;
  localparam int unsigned REL_TIME_MSB     = 6;
  localparam int unsigned GL_HARD_BIT      = 0;
  localparam int unsigned GL_IMMEDIATE_BIT = 1;
  localparam int unsigned GL_AUTO_BIT      = 2;
  localparam int unsigned GL_BYPASS_BIT    = 3;
  localparam int unsigned GL_RAMP_EN_BIT   = 4;
  localparam int unsigned GL_RAMP_UNIT_BIT = 5;
  localparam int unsigned GL_CLR_BIT       = 7;
  localparam int unsigned GH_EXP_LSB       = 0;
  localparam int unsigned GH_ZLEN_LSB      = 3;
  localparam int unsigned SIL_LEFT_BIT     = 0;
  localparam int unsigned SIL_RIGHT_BIT    = 1;

  // timing and levels
  localparam int unsigned SAMPLE_RATE_HZ   = 48000;
  localparam int unsigned MS_PER_SECOND    = 1000;
  localparam int unsigned SAMPLES_PER_MS   = SAMPLE_RATE_HZ / MS_PER_SECOND;
  localparam logic [3:0]  LONG_UNIT_MS     = 4'hA;
  localparam logic [12:0] ZERO_RUN_BASE    = 13'h0200;
  localparam logic [8:0]  ATT_SILENT       = 9'h0FF;
  localparam logic [7:0]  ATT_MAX_LIM      = 8'hFE;
  localparam logic [7:0]  LEVEL_CUT_HARD   = 8'hFF;
  localparam logic [8:0]  ATT_OCTAVE       = 9'h00C;
  localparam int unsigned MANT_FRAC_BITS   = 15;
  localparam int unsigned SAMPLE_W         = 24;

  typedef logic signed [SAMPLE_W-1:0] cdgm_sample_t;

  typedef struct packed {
    cdgm_sample_t left;
    cdgm_sample_t right;
  } cdgm_frame_s;

  typedef enum logic [0:0] {
    CDGM_HOLD_SILENT = 1'b0,
    CDGM_RUN         = 1'b1
  } cdgm_boot_e;

endpackage : cdgm_pkg

// [hw/cdgm_pair_buf.sv]
`timescale 1ns/1ps
// two-entry buffer; head is the output flop so the receiver sees registered data
module cdgm_pair_buf
  import cdgm_pkg::*;
#(
  parameter int unsigned WIDTH = 48
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  if (WIDTH < 1) begin : g_bad_width
    $error("cdgm_pair_buf: WIDTH must be at least 1");
  end

  logic             tail_valid;
  logic [WIDTH-1:0] tail;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // ready mirrors an empty tail in a flop of its own, so a stalled receiver stops the source
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_valid  <= 1'h0;
      tail_valid <= 1'h0;
      in_ready   <= 1'h1;
      out_data   <= '0;
      tail       <= '0;
    end else if (pop && tail_valid) begin
      out_data   <= tail;
      tail_valid <= 1'h0;
      in_ready   <= 1'h1;
    end else if (pop) begin
      out_valid <= push;
      if (push) out_data <= in_data;
    end else if (push && !out_valid) begin
      out_valid <= 1'h1;
      out_data  <= in_data;
    end else if (push) begin
      tail_valid <= 1'h1;
      in_ready   <= 1'h0;
      tail       <= in_data;
    end
  end

endmodule : cdgm_pair_buf

// [testbench/cdgm_host_model.sv]
`timescale 1ns/1ps
// register host; each access is followed by one idle cycle so strobes never toggle twice in a step
module cdgm_host_model (
  input  wire logic        clock,
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [7:0]  reg_rdata
);
  // idle bus values at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one write, called just after a rising edge; released lines show inverted values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clock);
    #1;
  endtask : wr
  // one read; data is registered, so it is taken just after the edge that samples the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clock);
    #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    @(posedge clock);
    #1;
  endtask : rd
endmodule : cdgm_host_model

// [testbench/class_d_gain_mute_control_bench.sv]
`timescale 1ns/1ps
module class_d_gain_mute_control_bench
  import cdgm_pkg::*;
;
  logic        clock, reset, reg_write, reg_read, global_silence, limiter_attack_step;
  logic        limiter_release_over, in_valid, in_ready, out_valid, out_ready, auto_silenced;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, limiter_cut, rv;
  logic [1:0]  limiter_step_code, limit_hit, limit_flag_status;
  cdgm_frame_s in_frame, out_frame, got;
  int          n_errors, num_checks, cycles;
  localparam cdgm_frame_s FR = 48'h3456780ABCDE;
  localparam cdgm_frame_s HALF = 48'h1A2B3C055E6F;  // twelve half-dB counts: one octave down

  // short time base keeps the release and ramp tests brief
  cdgm_gain_mute #(.SAMPLES_PER_UNIT(2)) cdgm_gain_mute_inst (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .global_silence(global_silence), .limiter_step_code(limiter_step_code),
    .limiter_attack_step(limiter_attack_step), .limiter_release_over(limiter_release_over),
    .limit_hit(limit_hit), .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame),
    .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame),
    .limit_flag_status(limit_flag_status), .limiter_cut(limiter_cut), .auto_silenced(auto_silenced));
  cdgm_host_model cdgm_host_model_inst (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // hang guard: a run well past the expected length counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input logic [47:0] g, input logic [47:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one frame in, one frame out with the receiver ready
  task automatic pass(input cdgm_frame_s f, output cdgm_frame_s o);
    in_valid = 1'b1;
    in_frame = f;
    while (!in_ready) tick();
    tick();
    in_valid = 0;
    in_frame = ~f;
    while (!out_valid) tick();
    o = out_frame;
    tick();
  endtask : pass
  // second frame is judged so a gain change landing on the first take does not matter
  task automatic mchk(input cdgm_frame_s e, input string m);
    pass(FR, got);
    pass(FR, got);
    chk(got, e, m);
  endtask : mchk
  task automatic test_regs();
    logic [15:0] a [6] = '{ADDR_RELEASE_TIME, ADDR_GAIN_HIGH, ADDR_GAIN_LOW, ADDR_SILENCE, ADDR_LEVEL_CUT, 16'hA225};
    logic [7:0]  r [6] = '{8'h00, 8'h15, 8'h05, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      cdgm_host_model_inst.rd(a[i], rv);
      chk(rv, r[i], "reset value");
    end
    cdgm_host_model_inst.wr(16'hA225, 8'h5A);
    cdgm_host_model_inst.rd(16'hA225, rv);
    chk(rv, 8'h00, "unmapped read");
    cdgm_host_model_inst.wr(ADDR_RELEASE_TIME, 8'hFF);
    cdgm_host_model_inst.rd(ADDR_RELEASE_TIME, rv);
    chk(rv, 8'hFF, "release time readback");
    cdgm_host_model_inst.wr(ADDR_RELEASE_TIME, 8'h01);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_stall();
    // receiver stalls: two frames fill the buffer, the third is refused; boot hold silences output
    out_ready = 1'b0;
    for (int i = 0; i < 2; i++) begin
      in_valid = 1'b1;
      in_frame = FR;
      tick();
    end
    chk(in_ready, 1'b0, "buffer full");
    chk(out_frame, 48'h0, "boot hold silent");
    in_valid = 1'b0;
    out_ready = 1'b1;
    repeat (3) tick();
    chk(out_valid, 1'b0, "buffer drained");
    $display("test_stall done");
  endtask : test_stall
  task automatic test_latch();
    limit_hit = 2'b01;
    tick();
    limit_hit = 2'b10;
    tick();
    limit_hit = 2'b00;
    chk(limit_flag_status, 2'b11, "latches set");
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h85);
    chk(limit_flag_status, 2'b00, "latches cleared");
    // the hit stands only in the clearing cycle, so a lost set cannot come back later
    limit_hit = 2'b01;
    fork
      cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h85);
      begin
        tick();
        limit_hit = 2'b00;
      end
    join
    chk(limit_flag_status, 2'b01, "set beats clear");
    $display("test_latch done");
  endtask : test_latch
  task automatic test_limiter();
    logic [7:0] e;
    e = 8'h00;
    for (int c = 0; c < 4; c++) begin
      limiter_step_code = 2'(c);
      limiter_attack_step = 1'b1;
      tick();
      limiter_attack_step = 1'b0;
      e = e + (8'h01 << c);
      chk(limiter_cut, e, "attack step");
    end
    repeat (10) pass(FR, got);
    chk(limiter_cut, 8'h0F, "release blocked over threshold");
    limiter_release_over = 1'b0;
    for (int k = 0; k < 20 && limiter_cut == 8'h0F; k++) pass(FR, got);
    chk(limiter_cut, 8'h07, "release step");
    for (int k = 0; k < 20 && limiter_cut == 8'h07; k++) pass(FR, got);
    chk(limiter_cut, 8'h00, "release floor");
    $display("test_limiter done");
  endtask : test_limiter
  task automatic test_mutes();
    // hard style, immediate change, multiply bypassed so passing samples are exact
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h0B);
    cdgm_host_model_inst.wr(ADDR_SILENCE, 8'h00);
    mchk(FR, "bypass pass-through");
    cdgm_host_model_inst.wr(ADDR_SILENCE, 8'h01);
    mchk({24'h0, FR.right}, "left silenced");
    cdgm_host_model_inst.wr(ADDR_SILENCE, 8'h02);
    mchk({FR.left, 24'h0}, "right silenced");
    cdgm_host_model_inst.wr(ADDR_SILENCE, 8'h00);
    global_silence = 1'b1;
    mchk(48'h0, "global silence");
    global_silence = 1'b0;
    cdgm_host_model_inst.wr(ADDR_LEVEL_CUT, 8'hFF);
    mchk(48'h0, "level cut hard mute");
    cdgm_host_model_inst.wr(ADDR_LEVEL_CUT, 8'h00);
    mchk(FR, "level cut 0 dB");
    // multiply on: both channels drop by exactly one shift
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h03);
    cdgm_host_model_inst.wr(ADDR_LEVEL_CUT, 8'h0C);
    mchk(HALF, "level cut 6 dB");
    // one-unit ramp: the second frame is still far from the new target
    cdgm_host_model_inst.wr(ADDR_GAIN_HIGH, 8'h10);
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h13);
    cdgm_host_model_inst.wr(ADDR_LEVEL_CUT, 8'h00);
    pass(FR, got);
    pass(FR, got);
    chk(got == FR, 1'b0, "ramp jumped");
    repeat (40) pass(FR, got);
    chk(got, FR, "ramp reached target");
    // zero-cross mode: positive frames keep the old cut until a zero sample
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h01);
    cdgm_host_model_inst.wr(ADDR_LEVEL_CUT, 8'h0C);
    mchk(FR, "cut held off crossing");
    pass(48'h0, got);
    mchk(HALF, "cut applied at crossing");
    $display("test_mutes done");
  endtask : test_mutes
  task automatic test_zero_run();
    cdgm_host_model_inst.wr(ADDR_GAIN_HIGH, 8'h05);
    cdgm_host_model_inst.wr(ADDR_GAIN_LOW, 8'h07);  // auto silence back on, hard style
    repeat (511) pass(48'h0, got);
    chk(auto_silenced, 1'b0, "no auto silence before 512");
    pass(48'h0, got);
    chk(auto_silenced, 1'b1, "auto silence after 512");
    pass(FR, got);
    chk(got, 48'h0, "auto silence mutes");
    $display("test_zero_run done");
  endtask : test_zero_run
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // reset, then the scenarios in order; zero-run last since auto silence stays on
  initial begin
    reset = 1'b1;
    {global_silence, limiter_attack_step, in_valid, out_ready} = 4'h0;
    limiter_release_over = 1'b1;
    limiter_step_code = 2'b00;
    limit_hit = 2'b00;
    in_frame = 48'h0;
    repeat (20) tick();
    reset = 1'b0;
    tick();
    test_regs();
    test_stall();
    test_latch();
    test_limiter();
    test_mutes();
    test_zero_run();
    complete_run();
  end
endmodule : class_d_gain_mute_control_bench
